// ---- logic/tpc_regs.svh ----
/*
 * Register offsets, field positions, reset values and timing counts for the trickle power and clock select block.
 * Assumes an 8-bit register port and a 125 MHz system clock.
 */
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH

// Register offsets on the 8-bit register port.
`define TPC_PWR_CTRL_OFS   8'h22
`define TPC_PLL_CTRL_OFS   8'h24
`define TPC_WAKE_EN_OFS    8'h30
`define TPC_WAKE_STS_OFS   8'h31
`define TPC_PORT_CTRL_OFS  8'h32
`define TPC_GPIO43_CFG_OFS 8'h33
`define TPC_STATUS_OFS     8'h34
`define TPC_SENSE_OFS      8'hf0

// Field positions.
`define TPC_PME_POWER_BIT  7
`define TPC_PLL_CTRL_BIT   1
`define TPC_ABSENT_BIT     0
`define TPC_ACTIVATE_BIT   0
`define TPC_TX2_SEL_BIT    1
`define TPC_IR_EN_BIT      2

// Reset values.
`define TPC_PWR_CTRL_RST   8'h00
`define TPC_PLL_CTRL_RST   8'h00
`define TPC_SENSE_RST      8'h00
`define TPC_WAKE_EN_RST    8'h00
`define TPC_PORT_CTRL_RST  8'h00
`define TPC_GPIO43_CFG_RST 8'h00

// Timing: the derived slow clock tick, in hertz, and its cycle count at the system clock.
`define TPC_CLK_FREQ_HZ    125000000
`define TPC_SLOW_FREQ_HZ   32768
`define TPC_SLOW_DIV       (`TPC_CLK_FREQ_HZ / `TPC_SLOW_FREQ_HZ)

`endif

// ---- logic/tpc_pkg.sv ----
/*
 * Types shared by the trickle power and clock select block.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package tpc_pkg;

    // One-cycle wake event pulses, one per source.
    typedef struct packed {
        logic gpio;     // Any eligible GPIO wake input.
        logic tach;     // Either fan tachometer.
        logic key;      // Wake on specific key.
        logic ir;       // Consumer IR receive.
        logic mouse;    // Mouse data line activity.
        logic kbd;      // Keyboard data line activity.
        logic ring2;    // Second UART ring indicator.
        logic ring1;    // First UART ring indicator.
    } tpc_wake_type;

    // PLL power and select state.
    typedef struct packed {
        logic pll32_on; // Slow-clock PLL powered.
        logic pll14_on; // 14 MHz PLL powered.
        logic sel32;    // Slow-clock PLL selected for the IR block.
    } tpc_pll_type;

    // Register port request.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tpc_bus_type;

    // Power state of the PLL table.
    typedef enum logic [1:0] {
        TPC_PLL_OFF,
        TPC_PLL_14,
        TPC_PLL_32,
        TPC_PLL_BOTH
    } tpc_pll_mode_type;

endpackage

// ---- logic/tpc_top.sv ----
/*
 * Trickle power control, PLL select and slow clock select for the standby domain.
 * Assumes rstn_i is the trickle-supply power-on reset, main_rst_i a synchronous main-supply or hard reset level,
 * and every other input synchronous to clk_i.
 */
// Function
// - No bus decode while supply not ok.
// - PLLs off when control set or all low.
// - Supply ok only: 14MHz PLL runs, selected.
// - Power bit only: slow PLL runs, selected.
// - Both set: both PLLs run, 14MHz selected.
// - Power bit resets 0, affects IR only.
// - Absent flag at 0xF0 bit 0, resets 0.
// - Flag picks derived or external slow clock.
// - Derived clock stops on trickle power only.
// - Enabled wake sources pull wake output low.
// - Second IR receive pin wakes as IR only.
// - Fan pins low outputs after main reset.
// - Multi-function pin reverts to GPIO, keeps config.
// - Three pins have no wake path.
// - Second IR transmit low until port activated.
// - UART2 transmit pin low until selected, activated.
// - UART2 transmit pin low output after resets.
// - Trickle reset initialises IR and wake state.
// - Wake pins stay active on trickle power.
// - Supply ok picks IR clock, enables timeout.
// - LED pins keep driving on trickle power.
`timescale 1ns/1ps
`include "tpc_regs.svh"

module tpc_top #(
    parameter int GPIO_WAKE_W = 8                     // Number of GPIO wake inputs.
) (
    input  wire logic                   clk_i,                  // System clock, 125 MHz.
    input  wire logic                   rstn_i,                 // Trickle-supply power-on reset, active low.
    input  wire logic                   main_rst_i,             // Main-supply or hard reset, active high.
    input  wire logic                   supply_ok_internal_i,   // Main supply above threshold.
    input  wire tpc_pkg::tpc_bus_type   bus_i,                  // Register port request.
    output logic [7:0]                  rdata_o,                // Read data, one cycle after the read strobe.
    input  wire tpc_pkg::tpc_wake_type  wake_src_i,             // Wake pulses, gpio field unused.
    input  wire logic [GPIO_WAKE_W-1:0] gpio_wake_i,            // Eligible GPIO wake pulses.
    input  wire logic                   ir_receive_second_i,    // Second IR receive pin event pulse.
    output logic                        wake_event_out_n_o,     // Wake event output, active low.
    output tpc_pkg::tpc_pll_type        pll_o,                  // PLL power and select.
    input  wire logic                   slow_clock_pin_i,       // External slow clock pin level.
    output logic                        slow_tick_o,            // Slow clock tick for timer logic.
    output logic                        ir_clk_main_o,          // IR block runs from the main clock source.
    output logic                        ir_hd_timeout_en_o,     // IR half-duplex timeout enabled.
    input  wire logic                   ir_tx_i,                // IR block transmit output.
    input  wire logic                   uart2_tx_i,             // Serial port 2 transmitter.
    output logic                        ir_transmit_second_o,   // Dedicated second IR transmit pin.
    output logic                        ir_transmit_second_oe_o,// Its output enable.
    output logic                        gpio_5_3_o,             // Shared UART2 transmit pin.
    output logic                        gpio_5_3_oe_o,          // Its output enable.
    input  wire logic [1:0]             fan_drive_i,            // Fan control drive from fan logic.
    output logic [1:0]                  fan_o,                  // Fan control pins.
    output logic [1:0]                  fan_oe_o,               // Their output enables.
    input  wire logic [1:0]             led_i,                  // LED control logic outputs.
    output logic [1:0]                  led_o,                  // LED pins.
    output logic                        gpio_4_3_alt_o,         // Multi-function pin alternate function on.
    output logic [2:0]                  gpio_4_3_cfg_o          // Direction, invert, buffer type.
);
    import tpc_pkg::*;

    localparam logic [11:0] SLOW_DIV = 12'(`TPC_SLOW_DIV);    // Derived tick period in cycles.

    logic [7:0]       pwr_ctrl_r;       // Holds the POWER_EVENT power bit.
    logic [7:0]       pll_ctrl_r;       // Holds the PLL control bit.
    logic [7:0]       sense_r;          // Slow clock sense register.
    logic [7:0]       wake_en_r;        // Wake source enables.
    logic [7:0]       wake_sts_r;       // Sticky wake status.
    logic [7:0]       port_ctrl_r;      // Activate, transmit select and IR enable.
    logic [7:0]       gpio43_cfg_r;     // Multi-function pin configuration.
    logic [11:0]      div_r;            // Derived slow clock divider.
    logic             ext_q_r;          // Last sampled external slow clock level.
    logic             ir2_hold_r;       // Second IR transmit held low.
    logic             tx2_hold_r;       // Shared transmit pin held low.
    logic             wr_ok;            // Write accepted.
    logic             rd_ok;            // Read accepted.
    logic             act_wr;           // Write that sets the activate bit.
    logic             derived_tick;     // Tick from the internal divider.
    logic             ext_tick;         // Rising edge of the external slow clock.
    tpc_wake_type     wake_ev;          // Wake events after routing.
    tpc_pll_mode_type pll_mode;         // Decoded PLL table row.
    logic [7:0]       rdata_nxt;        // Read data next value.
    logic             pme_power;        // POWER_EVENT power bit.
    logic             pll_ctl;          // PLL control bit.

    // Decode is blocked while the main supply is low so that pin noise never lands in a register.
    assign wr_ok = bus_i.wr & supply_ok_internal_i;
    assign rd_ok = bus_i.rd & supply_ok_internal_i;
    assign act_wr = wr_ok && bus_i.addr == `TPC_PORT_CTRL_OFS && bus_i.wdata[`TPC_ACTIVATE_BIT];
    assign pme_power = pwr_ctrl_r[`TPC_PME_POWER_BIT];
    assign pll_ctl = pll_ctrl_r[`TPC_PLL_CTRL_BIT];

    // Configuration registers live on the trickle supply, so only the trickle reset clears them.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwr_ctrl_r  <= `TPC_PWR_CTRL_RST;
            pll_ctrl_r  <= `TPC_PLL_CTRL_RST;
            sense_r     <= `TPC_SENSE_RST;
            wake_en_r   <= `TPC_WAKE_EN_RST;
            port_ctrl_r <= `TPC_PORT_CTRL_RST;
            gpio43_cfg_r <= `TPC_GPIO43_CFG_RST;
        end else if (wr_ok) begin
            case (bus_i.addr)
                `TPC_PWR_CTRL_OFS:  pwr_ctrl_r  <= bus_i.wdata & 8'h80;
                `TPC_PLL_CTRL_OFS:  pll_ctrl_r  <= bus_i.wdata & 8'h02;
                `TPC_SENSE_OFS:     sense_r     <= bus_i.wdata & 8'h01;
                `TPC_WAKE_EN_OFS:   wake_en_r   <= bus_i.wdata;
                `TPC_PORT_CTRL_OFS: port_ctrl_r <= bus_i.wdata & 8'h07;
                `TPC_GPIO43_CFG_OFS: gpio43_cfg_r <= bus_i.wdata & 8'h0f;
                default:            ;
            endcase
        end
    end

    // Route the second IR receive pin into the IR source only; the three pins without a trickle input path
    // are simply not wired into the GPIO vector.
    always_comb begin
        wake_ev      = wake_src_i;
        wake_ev.ir   = wake_src_i.ir | ir_receive_second_i;
        wake_ev.gpio = |gpio_wake_i;
    end

    // Wake status is sticky; a new event in the clearing cycle wins over the write-one clear.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wake_sts_r <= 8'h00;
        end else begin
            wake_sts_r <= (wake_sts_r & ~((wr_ok && bus_i.addr == `TPC_WAKE_STS_OFS) ? bus_i.wdata : 8'h00))
                          | (wake_ev & wake_en_r);
        end
    end

    // The wake output is not gated by the supply, so it keeps working on trickle power alone.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wake_event_out_n_o <= 1'b1;
        end else begin
            wake_event_out_n_o <= ~|wake_sts_r;
        end
    end

    // PLL table decode. The POWER_EVENT power bit only touches the IR clocking here.
    always_comb begin
        if (pll_ctl) begin
            pll_mode = TPC_PLL_OFF;
        end else begin
            case ({pme_power, supply_ok_internal_i})
                2'b00:   pll_mode = TPC_PLL_OFF;
                2'b01:   pll_mode = TPC_PLL_14;
                2'b10:   pll_mode = TPC_PLL_32;
                2'b11:   pll_mode = TPC_PLL_BOTH;
                default: pll_mode = TPC_PLL_OFF;
            endcase
        end
    end

    // Register the PLL state so that the outputs change cleanly.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pll_o <= '0;
        end else begin
            pll_o.pll32_on <= pll_mode == TPC_PLL_32 || pll_mode == TPC_PLL_BOTH;
            pll_o.pll14_on <= pll_mode == TPC_PLL_14 || pll_mode == TPC_PLL_BOTH;
            pll_o.sel32    <= pll_mode == TPC_PLL_32;
        end
    end

    // The IR block follows the main clock while the supply is good, and its timeout only runs then.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ir_clk_main_o      <= 1'b0;
            ir_hd_timeout_en_o <= 1'b0;
        end else begin
            ir_clk_main_o      <= supply_ok_internal_i;
            ir_hd_timeout_en_o <= supply_ok_internal_i;
        end
    end

    // Internal divider stands in for the slow clock derived from the main oscillator; it only runs on main power.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_r <= 12'h000;
        end else if (!supply_ok_internal_i || div_r == SLOW_DIV - 12'h001) begin
            div_r <= 12'h000;
        end else begin
            div_r <= div_r + 12'h001;
        end
    end

    assign derived_tick = supply_ok_internal_i && div_r == SLOW_DIV - 12'h001;
    assign ext_tick = slow_clock_pin_i & ~ext_q_r;

    // Edge detect on the external pin and select the tick source from the absent flag.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ext_q_r     <= 1'b0;
            slow_tick_o <= 1'b0;
        end else begin
            ext_q_r     <= slow_clock_pin_i;
            slow_tick_o <= sense_r[`TPC_ABSENT_BIT] ? derived_tick : ext_tick;
        end
    end

    // Transmit holds: set by any power-on or hard reset, released only by a write that activates the port,
    // because the activate bit itself survives a main-supply reset.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ir2_hold_r <= 1'b1;
            tx2_hold_r <= 1'b1;
        end else if (main_rst_i) begin
            ir2_hold_r <= 1'b1;
            tx2_hold_r <= 1'b1;
        end else begin
            if (act_wr) begin
                ir2_hold_r <= 1'b0;
            end
            if (act_wr && bus_i.wdata[`TPC_TX2_SEL_BIT]) begin
                tx2_hold_r <= 1'b0;
            end
        end
    end

    // Transmit pins are always driven; with no main supply they sit low.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ir_transmit_second_o    <= 1'b0;
            ir_transmit_second_oe_o <= 1'b1;
            gpio_5_3_o              <= 1'b0;
            gpio_5_3_oe_o           <= 1'b1;
        end else begin
            ir_transmit_second_oe_o <= 1'b1;
            gpio_5_3_oe_o           <= 1'b1;
            // The reset level gates the pins too, so they drop on the same edge that sets the holds.
            ir_transmit_second_o    <= supply_ok_internal_i && !main_rst_i && !ir2_hold_r && ir_tx_i;
            if (!supply_ok_internal_i || main_rst_i || tx2_hold_r || !port_ctrl_r[`TPC_TX2_SEL_BIT]) begin
                gpio_5_3_o <= 1'b0;
            end else begin
                gpio_5_3_o <= port_ctrl_r[`TPC_IR_EN_BIT] ? ir_tx_i : uart2_tx_i;
            end
        end
    end

    // Fan pins come up driven low and are never read back as wake inputs.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fan_o    <= 2'b00;
            fan_oe_o <= 2'b11;
        end else if (main_rst_i || !supply_ok_internal_i) begin
            fan_o    <= 2'b00;
            fan_oe_o <= 2'b11;
        end else begin
            fan_o    <= fan_drive_i;
            fan_oe_o <= 2'b11;
        end
    end

    // LED pins follow their control logic whatever the main supply does.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            led_o <= 2'b00;
        end else begin
            led_o <= led_i;
        end
    end

    // Without main supply the pin drops its alternate function; the stored configuration is left untouched.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gpio_4_3_alt_o <= 1'b0;
            gpio_4_3_cfg_o <= 3'b000;
        end else begin
            gpio_4_3_alt_o <= supply_ok_internal_i & gpio43_cfg_r[3];
            gpio_4_3_cfg_o <= gpio43_cfg_r[2:0];
        end
    end

    // Read mux; unmapped offsets read zero.
    always_comb begin
        case (bus_i.addr)
            `TPC_PWR_CTRL_OFS:  rdata_nxt = pwr_ctrl_r;
            `TPC_PLL_CTRL_OFS:  rdata_nxt = pll_ctrl_r;
            `TPC_SENSE_OFS:     rdata_nxt = sense_r;
            `TPC_WAKE_EN_OFS:   rdata_nxt = wake_en_r;
            `TPC_WAKE_STS_OFS:  rdata_nxt = wake_sts_r;
            `TPC_PORT_CTRL_OFS: rdata_nxt = port_ctrl_r;
            `TPC_GPIO43_CFG_OFS: rdata_nxt = gpio43_cfg_r;
            `TPC_STATUS_OFS:    rdata_nxt = {4'h0, pll_o.sel32, pll_o.pll14_on, pll_o.pll32_on, supply_ok_internal_i};
            default:            rdata_nxt = 8'h00;
        endcase
    end

    // Read data stands for one cycle only and reads zero otherwise.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_ok ? rdata_nxt : 8'h00;
        end
    end

    // Checks on the block's registers and outputs.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    property p_no_decode;
        bus_i.wr && !supply_ok_internal_i |=> $stable(sense_r) && $stable(wake_en_r) && $stable(pll_ctrl_r);
    endproperty
    a_no_decode: assert property (p_no_decode) else $error("Write decoded while supply low.");

    property p_pll_off;
        pll_ctl || (!pme_power && !supply_ok_internal_i) |=> !pll_o.pll32_on && !pll_o.pll14_on;
    endproperty
    a_pll_off: assert property (p_pll_off) else $error("PLL powered when it should be off.");

    property p_pll_14;
        !pll_ctl && !pme_power && supply_ok_internal_i |=> pll_o.pll14_on && !pll_o.pll32_on && !pll_o.sel32;
    endproperty
    a_pll_14: assert property (p_pll_14) else $error("Main PLL row wrong.");

    property p_pll_32;
        !pll_ctl && pme_power && !supply_ok_internal_i |=> pll_o.sel32 && pll_o.pll32_on && !pll_o.pll14_on;
    endproperty
    a_pll_32: assert property (p_pll_32) else $error("Slow PLL row wrong.");

    property p_pll_both;
        !pll_ctl && pme_power && supply_ok_internal_i |=> pll_o.pll14_on && pll_o.pll32_on && !pll_o.sel32;
    endproperty
    a_pll_both: assert property (p_pll_both) else $error("Both PLL row wrong.");

    property p_wake;
        (|(wake_ev & wake_en_r)) |=> ##1 !wake_event_out_n_o;
    endproperty
    a_wake: assert property (p_wake) else $error("Enabled wake event did not assert output.");

    property p_tick_src;
        !supply_ok_internal_i && sense_r[0] |=> !slow_tick_o;
    endproperty
    a_tick_src: assert property (p_tick_src) else $error("Derived tick ran without main supply.");

    property p_tx2_low;
        main_rst_i |=> !gpio_5_3_o && gpio_5_3_oe_o && !ir_transmit_second_o ##1 !gpio_5_3_o;
    endproperty
    a_tx2_low: assert property (p_tx2_low) else $error("Transmit pin not low after reset.");

    property p_fan_low;
        main_rst_i |=> fan_o == 2'b00 && fan_oe_o == 2'b11;
    endproperty
    a_fan_low: assert property (p_fan_low) else $error("Fan pins not driven low after reset.");

    c_wake: cover property (!wake_event_out_n_o && !supply_ok_internal_i);
    c_act: cover property ($fell(ir2_hold_r));
    c_sel32: cover property (pll_o.sel32);

endmodule

// ---- verif/tpc_slow_src.sv ----
/* Far-side model: the external slow clock source that feeds the slow clock pin.
   Assumes the bench clock and a run enable that starts and stops the source. */
`timescale 1ns/1ps
module tpc_slow_src (
    input  wire logic clk_i,   // Bench clock.
    input  wire logic run_i,   // The source runs only while this is high.
    output logic      pin_o,   // Slow clock pin level.
    output int        rises_o  // Rising edges sent so far.
);
    logic [3:0] div_r;  // Half-period counter.
    initial begin
        pin_o = 1'b0;
        rises_o = 0;
        div_r = 4'h0;
    end
    // The pin stands still while stopped, so no stray edge reaches the block.
    always @(posedge clk_i) begin
        if (run_i) begin
            div_r <= div_r + 4'h1;
            if (div_r == 4'hf) begin
                pin_o <= ~pin_o;
                rises_o <= rises_o + int'(!pin_o);
            end
        end
    end
endmodule

// ---- verif/test_tpc_top.sv ----
/* Self-checking bench for the trickle power and clock select block.
   Assumes the register port settles read data one cycle after the read strobe. */
`timescale 1ns/1ps
module test_tpc_top;
    import tpc_pkg::*;
    logic clk_i, rstn_i, main_rst_i, supply_ok_internal_i, slow_clock_pin_i, ir_receive_second_i;
    logic ir_tx_i, uart2_tx_i, slow_tick_o, ir_clk_main_o, ir_hd_timeout_en_o, wake_event_out_n_o, run;
    logic ir_transmit_second_o, ir_transmit_second_oe_o, gpio_5_3_o, gpio_5_3_oe_o, gpio_4_3_alt_o;
    logic [7:0] rdata_o, gpio_wake_i;
    logic [1:0] fan_drive_i, fan_o, fan_oe_o, led_i, led_o;
    logic [2:0] gpio_4_3_cfg_o;
    tpc_bus_type  bus_i;
    tpc_wake_type wake_src_i;
    tpc_pll_type  pll_o;
    int errors, n_checks, cycles, ticks, rises, base;
    tpc_top u_tpc_top (.clk_i, .rstn_i, .main_rst_i, .supply_ok_internal_i, .bus_i, .rdata_o, .wake_src_i,
        .gpio_wake_i, .ir_receive_second_i, .wake_event_out_n_o, .pll_o, .slow_clock_pin_i, .slow_tick_o,
        .ir_clk_main_o, .ir_hd_timeout_en_o, .ir_tx_i, .uart2_tx_i, .ir_transmit_second_o,
        .ir_transmit_second_oe_o, .gpio_5_3_o, .gpio_5_3_oe_o, .fan_drive_i, .fan_o, .fan_oe_o, .led_i,
        .led_o, .gpio_4_3_alt_o, .gpio_4_3_cfg_o);
    tpc_slow_src u_tpc_slow_src (.clk_i(clk_i), .run_i(run), .pin_o(slow_clock_pin_i), .rises_o(rises));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // Hang guard: the whole run needs about 16100 cycles.
    always @(posedge clk_i) begin
        cycles++;
        ticks <= ticks + int'(slow_tick_o === 1'b1);
        if (cycles == 40000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i <= '0;
    endtask
    // Read data are looked at only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i <= '0;
        #1 chk(what, exp, rdata_o);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic pulse(input tpc_wake_type s, input logic rx2, input logic exp_n);
        @(posedge clk_i);
        wake_src_i <= s;
        ir_receive_second_i <= rx2;
        @(posedge clk_i);
        wake_src_i <= '0;
        ir_receive_second_i <= 1'b0;
        idle(3);
        chk("wake out", {7'h0, exp_n}, {7'h0, wake_event_out_n_o});
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Expected PLL state {slow on, fast on, slow selected}.
    function automatic logic [2:0] exp_pll(input logic c, input logic p, input logic k);
        if (c || (!p && !k)) return 3'b000;
        return !p ? 3'b010 : (k ? 3'b110 : 3'b101);
    endfunction
    initial begin
        {rstn_i, main_rst_i, ir_receive_second_i, run, uart2_tx_i} = '0;
        {supply_ok_internal_i, ir_tx_i} = 2'b11;
        {bus_i, wake_src_i, gpio_wake_i, led_i, fan_drive_i} = '0;
        {errors, n_checks, cycles, ticks} = '0;
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(8'h22, 8'h00, "power reg reset");
        rd(8'hf0, 8'h00, "sense reg reset");
        rd(8'h40, 8'h00, "unmapped read");
        chk("pll after reset", {5'h0, exp_pll(1'b0, 1'b0, 1'b1)}, {5'h0, pll_o});
        chk("tx pins reset", 8'h03, {4'h0, ir_transmit_second_o, gpio_5_3_o, ir_transmit_second_oe_o, gpio_5_3_oe_o});
        fan_drive_i <= 2'b11;
        idle(2);
        chk("fan follows", 8'h0f, {4'h0, fan_o, fan_oe_o});
        main_rst_i <= 1'b1;
        idle(2);
        chk("fan in main reset", 8'h03, {4'h0, fan_o, fan_oe_o});
        main_rst_i <= 1'b0;
        supply_ok_internal_i <= 1'b0;
        wr(8'hf0, 8'h01);
        rd(8'hf0, 8'h00, "read while supply low");
        supply_ok_internal_i <= 1'b1;
        rd(8'hf0, 8'h00, "write while supply low");
        for (int i = 0; i < 8; i++) begin
            supply_ok_internal_i <= 1'b1;
            wr(8'h24, {6'h0, i[2], 1'b0});
            wr(8'h22, {i[1], 7'h0});
            supply_ok_internal_i <= i[0];
            idle(3);
            chk("pll table", {5'h0, exp_pll(i[2], i[1], i[0])}, {5'h0, pll_o});
            chk("ir clock", {6'h0, i[0], i[0]}, {6'h0, ir_clk_main_o, ir_hd_timeout_en_o});
        end
        supply_ok_internal_i <= 1'b1;
        wr(8'h24, 8'h00);
        wr(8'h30, 8'h04);
        supply_ok_internal_i <= 1'b0;
        pulse(8'h04, 1'b0, 1'b0);
        supply_ok_internal_i <= 1'b1;
        wr(8'h31, 8'h04);
        pulse(8'h01, 1'b0, 1'b1);
        wr(8'h30, 8'h80);
        pulse(8'h80, 1'b1, 1'b1);
        wr(8'h30, 8'h10);
        pulse(8'h00, 1'b1, 1'b0);
        wr(8'h31, 8'h10);
        wr(8'h32, 8'h01);
        idle(2);
        chk("tx after activate", 8'h02, {6'h0, ir_transmit_second_o, gpio_5_3_o});
        wr(8'h32, 8'h03);
        uart2_tx_i <= 1'b1;
        ir_tx_i <= 1'b0;
        idle(2);
        chk("tx2 serial", 8'h01, {6'h0, ir_transmit_second_o, gpio_5_3_o});
        wr(8'h32, 8'h07);
        idle(2);
        chk("tx2 ir", 8'h00, {6'h0, ir_transmit_second_o, gpio_5_3_o});
        ir_tx_i <= 1'b1;
        main_rst_i <= 1'b1;
        idle(2);
        chk("tx after main reset", 8'h00, {6'h0, ir_transmit_second_o, gpio_5_3_o});
        main_rst_i <= 1'b0;
        wr(8'h33, 8'h0d);
        idle(2);
        chk("gpio43 main", 8'h0d, {4'h0, gpio_4_3_alt_o, gpio_4_3_cfg_o});
        supply_ok_internal_i <= 1'b0;
        led_i <= 2'b10;
        idle(2);
        chk("gpio43 trickle", 8'h05, {4'h0, gpio_4_3_alt_o, gpio_4_3_cfg_o});
        chk("led trickle", 8'h02, {6'h0, led_o});
        supply_ok_internal_i <= 1'b1;
        ticks = 0;
        base = rises;
        run <= 1'b1;
        idle(300);
        run <= 1'b0;
        idle(4);
        chk("external ticks", 8'(rises - base), 8'(ticks));
        wr(8'hf0, 8'h01);
        idle(1);
        supply_ok_internal_i <= 1'b0;
        ticks = 0;
        idle(8000);
        chk("derived ticks trickle", 8'h00, 8'(ticks));
        supply_ok_internal_i <= 1'b1;
        ticks = 0;
        idle(7700);
        chk("derived ticks main", 8'h01, {7'h0, ticks == 2 || ticks == 3});
        end_of_test();
    end
endmodule
